// [sim/can_host_model.sv]
`timescale 1ns/1ps
// host protocol controller: owns the transmit pin, low is dominant
module can_host_model (
  // clock
  input  wire clk_i,
  // bench request
  input  wire send_dom_i,
  // pin
  output reg  tx_data_in_o
);
  // idles recessive
  // any early dominant is commanded by the bench on purpose
  initial tx_data_in_o = 1'b1;
  always @(posedge clk_i) begin
    tx_data_in_o <= !send_dom_i;
  end
endmodule

// [sim/can_trx_ctrl_properties.sv]
`timescale 1ns/1ps
// watches the pin side of the transceiver control; single clock domain
module can_trx_ctrl_properties #(
  parameter [15:0] TX_TO_CYC = 16'd50
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // pins watched
  input wire tx_data_in_i,
  input wire bus_rx_i,
  input wire rx_data_out_o,
  input wire int_n_o,
  input wire restart_req_o,
  input wire bus_drive_dom_o,
  input wire rx_enable_o
);
  reg [15:0] low_cnt_r;

  // length of the current dominant request; saturates so it never wraps
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i)
      low_cnt_r <= 16'h0;
    else if (tx_data_in_i)
      low_cnt_r <= 16'h0;
    else if (low_cnt_r != 16'hffff)
      low_cnt_r <= low_cnt_r + 16'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // six cycles cover the pin synchroniser and the output flop
  sequence s_tx_rec;
    tx_data_in_i [*6];
  endsequence
  sequence s_bus_rec;
    (rx_enable_o && bus_rx_i) [*6];
  endsequence

  a_off_after_reset: assert property ($fell(reset_i) |-> !bus_drive_dom_o && !rx_enable_o)
    else $error("active after reset");
  a_tx_follow: assert property (s_tx_rec |-> !bus_drive_dom_o)
    else $error("drive without request");
  a_drive_rx_on: assert property (bus_drive_dom_o |-> rx_enable_o)
    else $error("drive outside normal");
  a_rx_follow: assert property (s_bus_rec |-> rx_data_out_o)
    else $error("rx not recessive");
  a_tx_timeout: assert property (low_cnt_r > TX_TO_CYC + 16'd8 |-> !bus_drive_dom_o)
    else $error("no transmit timeout");
  a_int_pulse: assert property (!int_n_o |=> int_n_o)
    else $error("int too long");
  a_restart_pulse: assert property (restart_req_o |=> !restart_req_o)
    else $error("restart too long");
  a_no_int_sleep: assert property (restart_req_o |-> int_n_o ##1 int_n_o)
    else $error("int on sleep wake");
  a_int_rx_low: assert property ($fell(int_n_o) |-> ##[0:6] !rx_data_out_o)
    else $error("rx not low on wake");
endmodule

bind can_trx_ctrl can_trx_ctrl_properties #(.TX_TO_CYC(TX_TO_CYC)) can_trx_ctrl_properties_inst (
  .clk_i(clk_i), .reset_i(reset_i), .tx_data_in_i(tx_data_in_i), .bus_rx_i(bus_rx_i),
  .rx_data_out_o(rx_data_out_o), .int_n_o(int_n_o), .restart_req_o(restart_req_o),
  .bus_drive_dom_o(bus_drive_dom_o), .rx_enable_o(rx_enable_o));

// [sim/can_trx_ctrl_tb.sv]
`timescale 1ns/1ps
`include "can_trx_map.vh"
module can_trx_ctrl_tb;
  reg          clk_i = 1'b0;
  reg          reset_i = 1'b1;
  reg          ce_i = 1'b1;
  reg          psel_i = 1'b0;
  reg          penable_i = 1'b0;
  reg          pwrite_i = 1'b0;
  reg  [7:0]   paddr_i = 8'h00;
  reg  [31:0]  pwdata_i = 32'h0;
  reg  [2:0]   chip_mode_i = 3'h0;
  reg          chip_mode_strobe_i = 1'b0;
  reg          send_dom = 1'b0;
  reg          bus_rx_i = 1'b1;
  wire         tx_data_in_i;
  wire [31:0]  prdata_o;
  wire         pready_o, pslverr_o, restart_req_o, wdog_enable_o;
  wire         rx_data_out_o, int_n_o, bus_drive_dom_o, rx_enable_o;
  integer      miscompares = 0;
  integer      checked = 0;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic        err;
  int          k;

  // clock of 100 ns
  initial forever #50 clk_i = ~clk_i;

  // short timing parameters keep the run brief
  can_trx_ctrl #(.EN_SETTLE_CYC(16'd8), .WAKE_MIN_CYC(16'd3), .WAKE_MAX_CYC(16'd40),
    .TX_TO_CYC(16'd50), .BUS_TO_CYC(16'd50)) can_trx_ctrl_inst (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .chip_mode_i(chip_mode_i),
    .chip_mode_strobe_i(chip_mode_strobe_i), .restart_req_o(restart_req_o),
    .wdog_enable_o(wdog_enable_o), .tx_data_in_i(tx_data_in_i), .rx_data_out_o(rx_data_out_o),
    .int_n_o(int_n_o), .bus_rx_i(bus_rx_i), .bus_drive_dom_o(bus_drive_dom_o), .rx_enable_o(rx_enable_o));

  can_host_model can_host_model_inst (.clk_i(clk_i), .send_dom_i(send_dom), .tx_data_in_o(tx_data_in_i));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one transfer; a read notes its expected word and mask for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    if (!w)
      exp_q.push_back({m, d});
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n = n + 1;
    end while (!pready_o && n < 20);
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (!pready_o) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  endtask

  // read data is compared at the edge that completes the read
  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o && !pwrite_i && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("prdata", prdata_o & e[63:32], e[31:0]);
    end
  end

  function automatic logic pin(input int s);
    case (s)
      0: pin = int_n_o;
      1: pin = restart_req_o;
      2: pin = bus_drive_dom_o;
      3: pin = rx_data_out_o;
      4: pin = wdog_enable_o;
      default: pin = rx_enable_o;
    endcase
  endfunction

  // outputs are looked at on the falling edge, where they have settled
  task automatic wait_pin(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n = n + 1;
    end while (pin(s) !== lvl && n < lim);
    chk("pin", {31'h0, pin(s)}, {31'h0, lvl});
    if (pin(s) !== lvl)
      end_sim();
  endtask

  task automatic hold_pin(input int s, input logic lvl, input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(negedge clk_i);
      if (pin(s) !== lvl)
        bad = 1'b1;
    end
    chk("hold", {31'h0, bad}, 32'h0);
  endtask

  task automatic bus(input logic lvl, input int n);
    @(posedge clk_i);
    bus_rx_i <= lvl;
    repeat (n - 1) @(posedge clk_i);
  endtask

  task automatic tx(input logic dom, input int n);
    @(posedge clk_i);
    send_dom <= dom;
    repeat (n - 1) @(posedge clk_i);
  endtask

  task automatic chip(input logic [2:0] m);
    @(posedge clk_i);
    chip_mode_i <= m;
    chip_mode_strobe_i <= 1'b1;
    @(posedge clk_i);
    chip_mode_strobe_i <= 1'b0;
  endtask

  // random phases stay well inside the wake window of 3 to 40 cycles
  task automatic wake_try(input int s, input logic lvl, input logic hold);
    fork
      begin
        bus(1'b0, 6 + $urandom % 20);
        bus(1'b1, 6 + $urandom % 20);
        bus(1'b0, 6 + $urandom % 20);
        bus(1'b1, 4);
      end
      if (hold)
        hold_pin(s, lvl, 90);
      else
        wait_pin(s, lvl, 100);
    join
  endtask

  initial begin
    k = $urandom(32'h5f7528f3);
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    apb(1'b0, `REG_CTRL_OFF, 32'h0, 32'h7);
    apb(1'b0, 8'h0c, 32'h0, 32'hffffffff);
    chk("slverr", {31'h0, err}, 32'h1); // refused address
    hold_pin(5, 1'b0, 2);
    wake_try(3, 1'b1, 1'b1);
    apb(1'b0, `REG_WAKE_STAT_OFF, 32'h0, 32'h3);
    $display("test off done");
    chip(`CHIP_STOP);
    apb(1'b1, `REG_CTRL_OFF, 32'h3, 32'h0);
    apb(1'b0, `REG_CTRL_OFF, 32'h0, 32'h3);
    apb(1'b1, `REG_CTRL_OFF, 32'h2, 32'h0);
    apb(1'b0, `REG_CTRL_OFF, 32'h2, 32'h3);
    fork
      tx(1'b1, 20);
      hold_pin(2, 1'b0, 20);
      hold_pin(5, 1'b1, 20);
      bus(1'b0, 12);
      wait_pin(3, 1'b0, 10);
    join
    tx(1'b0, 2);
    bus(1'b1, 6);
    $display("test rx-only done");
    chip(`CHIP_NORMAL);
    apb(1'b1, `REG_CTRL_OFF, 32'h3, 32'h0);
    fork
      tx(1'b1, 30);
      hold_pin(2, 1'b0, 28);
    join
    tx(1'b0, 6);
    fork
      tx(1'b1, 10);
      wait_pin(2, 1'b1, 8);
    join
    fork
      tx(1'b1, 70);
      wait_pin(2, 1'b0, 70);
    join
    apb(1'b0, `REG_STATUS_OFF, 32'h3, 32'h3);
    apb(1'b0, `REG_CTRL_OFF, 32'h3, 32'h3);
    tx(1'b0, 6);
    fork
      tx(1'b1, 10);
      wait_pin(2, 1'b1, 8);
    join
    tx(1'b0, 4);
    apb(1'b1, `REG_STATUS_OFF, 32'h7, 32'h0);
    bus(1'b0, 70);
    bus(1'b1, 6);
    apb(1'b0, `REG_STATUS_OFF, 32'h5, 32'h7);
    apb(1'b1, `REG_STATUS_OFF, 32'h7, 32'h0);
    $display("test normal done");
    apb(1'b1, `REG_CTRL_OFF, 32'h5, 32'h0);
    wake_try(0, 1'b0, 1'b0);
    wait_pin(3, 1'b0, 4);
    apb(1'b0, `REG_CTRL_OFF, 32'h5, 32'h7);
    apb(1'b0, `REG_WAKE_STAT_OFF, 32'h1, 32'h1);
    chip(`CHIP_STOP);
    wake_try(0, 1'b0, 1'b0);
    wait_pin(4, 1'b1, 4);
    wake_try(0, 1'b1, 1'b1);
    apb(1'b1, `REG_CTRL_OFF, 32'h0, 32'h0);
    apb(1'b1, `REG_CTRL_OFF, 32'h1, 32'h0);
    wake_try(0, 1'b0, 1'b0);
    $display("test wake done");
    apb(1'b1, `REG_CTRL_OFF, 32'h0, 32'h0);
    apb(1'b1, `REG_CTRL_OFF, 32'h1, 32'h0);
    chip(`CHIP_SLEEP);
    fork
      wake_try(1, 1'b1, 1'b0);
      hold_pin(0, 1'b1, 95);
    join
    apb(1'b0, `REG_WAKE_STAT_OFF, 32'h1, 32'h1);
    chip(`CHIP_FAILSAFE);
    apb(1'b0, `REG_CTRL_OFF, 32'h1, 32'h3);
    // clock enable low: a full pattern must leave no trace
    ce_i <= 1'b0;
    wake_try(1, 1'b0, 1'b1);
    @(posedge clk_i);
    ce_i <= 1'b1;
    wake_try(1, 1'b1, 1'b0);
    $display("test sleep done");
    end_sim();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares = miscompares + 1;
    end_sim();
  end
endmodule

// [verilog/can_trx_ctrl.v]
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "can_trx_map.vh"
// How it works
// (R1) powers up in off; off always selectable
// (R2) off mode ignores bus wake activity
// (R3) normal mode only in chip normal
// (R4) driver follows transmit input in normal
// (R5) host holds transmit high while settling
// (R6) early low blocks until high again
// (R7) receive output mirrors bus in normal/rx-only
// (R8) rx-only: driver off, chip normal/stop
// (R9) wake mode by command, forced in fail-safe
// (R10) wake needs dom-rec-dom bounded phases
// (R11) wake drives receive low until mode change
// (R12) mode field stays wake after wake event
// (R13) rearm by toggling mode away and back
// (R14) rearm on stop or fail-safe entry
// (R15) host selects wake or off before sleep
// (R16) wake in stop/normal raises interrupt, flag
// (R17) bus wake in chip stop enables watchdog if configured
// (R18) wake in sleep requests restart, flags source
// (R19) no interrupt when leaving sleep
// (R20) transmit timeout forces recessive, sets fault
// (R21) driver re-enabled once transmit input released
// (R22) bus dominant timeout sets fault flag
// (R23) all timings are cycle-count parameters
module can_trx_ctrl #(
  parameter [15:0] EN_SETTLE_CYC = `EN_SETTLE_CYC,
  parameter [15:0] WAKE_MIN_CYC  = `WAKE_MIN_CYC,
  parameter [15:0] WAKE_MAX_CYC  = `WAKE_MAX_CYC,
  parameter [15:0] TX_TO_CYC     = `TX_TO_CYC,
  parameter [15:0] BUS_TO_CYC    = `BUS_TO_CYC
) (
  // clock, reset, enable
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        ce_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // chip mode sequencer
  input  wire [2:0]  chip_mode_i,
  input  wire        chip_mode_strobe_i,
  output reg         restart_req_o,
  output reg         wdog_enable_o,
  // host pins
  input  wire        tx_data_in_i,
  output reg         rx_data_out_o,
  output reg         int_n_o,
  // bus side
  input  wire        bus_rx_i,
  output reg         bus_drive_dom_o,
  output reg         rx_enable_o
);
  // internal state; hardware sets each flag, a write of one clears it
  wire       tx_s;
  wire       bus_s;
  wire       wake_found;
  reg  [1:0] mode_r;
  reg        wdog_cfg_r;
  reg        armed_r;
  reg        woken_r;
  reg        wake_flag_r;
  reg        wake_wdog_r;
  reg        txto_r;
  reg        clamp_r;
  reg        fail_r;
  reg        blocked_r;
  reg        tx_lock_r;
  reg [15:0] settle_cnt_r;
  reg [15:0] tx_cnt_r;
  reg [15:0] bus_cnt_r;
  reg [2:0]  chip_prev_r;

  // apb handshake: setup phase seen, answer on second access cycle
  wire apb_acc = psel_i & penable_i & pready_o;
  wire apb_wr  = apb_acc & pwrite_i;
  wire apb_rd  = apb_acc & ~pwrite_i;
  // first access cycle: read data is latched here, the answer follows one cycle later
  wire apb_first = psel_i & penable_i & ~pready_o;
  wire wr_ctrl = apb_wr && (paddr_i == `REG_CTRL_OFF);
  wire wr_stat = apb_wr && (paddr_i == `REG_STATUS_OFF);
  wire wr_wake = apb_wr && (paddr_i == `REG_WAKE_STAT_OFF);
  wire [1:0] req_mode = pwdata_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];

  // the pins cross from outside the clock domain
  // three stages cost four cycles of latency against a pin edge
  pin_sync u_tx_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .pin_i   (tx_data_in_i),
    .level_o (tx_s)
  );

  pin_sync u_bus_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .pin_i   (bus_rx_i),
    .level_o (bus_s)
  );

  // (R2) detector runs only in armed wake mode
  // it stays disarmed after a find until a mode toggle or a stop or fail-safe entry
  wake_detect u_wake (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .arm_i     (armed_r && (mode_r == `TRX_WAKE) && !woken_r),
    .bus_dom_i (~bus_s),
    .min_cyc_i (WAKE_MIN_CYC),
    .max_cyc_i (WAKE_MAX_CYC),
    .found_o   (wake_found)
  );

  // whether a software mode request is legal in the current chip mode
  // wake mode in fail-safe is forced by hardware, so a write there is refused
  function mode_allowed;
    input [1:0] m;
    input [2:0] chip;
    begin
      case (m)
        `TRX_OFF:    mode_allowed = 1'b1;
        `TRX_NORMAL: mode_allowed = (chip == `CHIP_NORMAL);
        `TRX_RXONLY: mode_allowed = (chip == `CHIP_NORMAL) || (chip == `CHIP_STOP);
        `TRX_WAKE:   mode_allowed = (chip != `CHIP_FAILSAFE);
        default:     mode_allowed = 1'b0;
      endcase
    end
  endfunction

  // saturating up-counter used by all timers
  function [15:0] count_up;
    input [15:0] c;
    begin
      count_up = (c == 16'hffff) ? c : c + 16'h0001;
    end
  endfunction

  // only three word offsets are decoded; anything else answers with an error
  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a == `REG_CTRL_OFF) || (a == `REG_STATUS_OFF) || (a == `REG_WAKE_STAT_OFF);
    end
  endfunction

  // a stop strobe rearms even when the chip is already in stop
  wire stop_entry  = chip_mode_strobe_i && (chip_mode_i == `CHIP_STOP);
  wire fs_entry    = chip_mode_strobe_i && (chip_mode_i == `CHIP_FAILSAFE) && (chip_prev_r != `CHIP_FAILSAFE);
  wire mode_change = wr_ctrl && mode_allowed(req_mode, chip_mode_i) && (req_mode != mode_r);
  wire in_normal   = (mode_r == `TRX_NORMAL);
  wire rx_active   = in_normal || (mode_r == `TRX_RXONLY);
  wire tx_to_hit   = in_normal && !tx_s && (tx_cnt_r >= TX_TO_CYC);
  wire bus_to_hit  = rx_active && !bus_s && (bus_cnt_r >= BUS_TO_CYC);
  // settling over; before this the driver stays recessive whatever the input does
  wire settled     = (settle_cnt_r >= EN_SETTLE_CYC);

  // mode register and wake arming
  // fail-safe entry outranks a software write; a write outranks a wake find,
  // whose flag is still recorded by the status process
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      // (R1) off after power-up
      mode_r      <= `TRX_OFF;
      wdog_cfg_r  <= 1'b0;
      armed_r     <= 1'b0;
      woken_r     <= 1'b0;
      chip_prev_r <= `CHIP_NORMAL;
    end else if (ce_i) begin
      if (chip_mode_strobe_i) begin
        chip_prev_r <= chip_mode_i;
      end
      // the watchdog option is taken from every control write, legal mode or not
      if (wr_ctrl) begin
        wdog_cfg_r <= pwdata_i[`CTRL_WDOG_BIT];
      end
      if (fs_entry) begin
        // (R9) forced wake mode in fail-safe
        mode_r  <= `TRX_WAKE;
        armed_r <= 1'b1;
        woken_r <= 1'b0;
      end else if (stop_entry && (mode_r == `TRX_WAKE)) begin
        // (R14) rearm on stop entry
        armed_r <= 1'b1;
        woken_r <= 1'b0;
      end else if (mode_change) begin
        // (R3) (R8) (R9) request gated by chip mode
        mode_r <= req_mode;
        // (R13) rearm only on entry into wake
        armed_r <= (req_mode == `TRX_WAKE);
        woken_r <= 1'b0;
      end else if (wake_found) begin
        // (R12) mode field stays wake, detector disarmed
        woken_r <= 1'b1;
        armed_r <= 1'b0;
      end
    end
  end

  // transmit path: settling, early-low block, timeout
  // settling restarts on every entry to normal, so a quick off/normal toggle cannot skip it
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      settle_cnt_r <= 16'h0000;
      blocked_r    <= 1'b0;
      tx_lock_r    <= 1'b0;
      tx_cnt_r     <= 16'h0000;
      bus_cnt_r    <= 16'h0000;
    end else if (ce_i) begin
      if (!in_normal || mode_change) begin
        settle_cnt_r <= 16'h0000;
        blocked_r    <= 1'b0;
      end else if (settle_cnt_r < EN_SETTLE_CYC) begin
        settle_cnt_r <= count_up(settle_cnt_r);
        // (R6) low during settling is held off
        if (!tx_s) begin
          blocked_r <= 1'b1;
        end
      end else if (tx_s) begin
        // (R6) released once input returns high
        blocked_r <= 1'b0;
      end
      // (R23) timers count cycles of dominance
      // they saturate rather than wrap, so a stuck line keeps its fault asserted
      tx_cnt_r  <= (in_normal && !tx_s) ? count_up(tx_cnt_r) : 16'h0000;
      bus_cnt_r <= (rx_active && !bus_s) ? count_up(bus_cnt_r) : 16'h0000;
      if (tx_to_hit) begin
        // (R20) force recessive after timeout
        tx_lock_r <= 1'b1;
      end else if (tx_s || !in_normal) begin
        // (R21) re-enable when input released
        tx_lock_r <= 1'b0;
      end
    end
  end

  // status flags; hardware set wins over software clear
  // a clear written in the cycle of a new event is lost, never the event
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      txto_r      <= 1'b0;
      clamp_r     <= 1'b0;
      fail_r      <= 1'b0;
      wake_flag_r <= 1'b0;
      wake_wdog_r <= 1'b0;
    end else if (ce_i) begin
      // (R20) (R22) fault flag, mode untouched
      if (tx_to_hit || bus_to_hit) begin
        fail_r <= 1'b1;
      end else if (wr_stat && pwdata_i[`STAT_FAIL_BIT]) begin
        fail_r <= 1'b0;
      end
      if (tx_to_hit) begin
        txto_r <= 1'b1;
      end else if (wr_stat && pwdata_i[`STAT_TXTO_BIT]) begin
        txto_r <= 1'b0;
      end
      if (bus_to_hit) begin
        clamp_r <= 1'b1;
      end else if (wr_stat && pwdata_i[`STAT_CLAMP_BIT]) begin
        clamp_r <= 1'b0;
      end
      // (R16) (R18) wake source recorded
      if (wake_found) begin
        wake_flag_r <= 1'b1;
      end else if ((wr_wake && pwdata_i[`WAKE_FLAG_BIT]) || (mode_change && mode_r == `TRX_WAKE)) begin
        // (R13) leaving wake mode also clears the flag
        wake_flag_r <= 1'b0;
      end
      // (R17) watchdog wake recorded
      if (wake_found && wdog_cfg_r && chip_mode_i == `CHIP_STOP) begin
        wake_wdog_r <= 1'b1;
      end else if (wr_wake && pwdata_i[`WAKE_WDOG_BIT]) begin
        wake_wdog_r <= 1'b0;
      end
    end
  end

  // registered pins and requests
  // every pin is registered: one cycle of latency buys glitch-free outputs
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_data_out_o   <= 1'b1;
      bus_drive_dom_o <= 1'b0;
      rx_enable_o     <= 1'b0;
      int_n_o         <= 1'b1;
      restart_req_o   <= 1'b0;
      wdog_enable_o   <= 1'b0;
    end else if (ce_i) begin
      // (R4) (R8) driver only in normal, gated by settling and timeout
      bus_drive_dom_o <= in_normal && !tx_s && !blocked_r && !tx_lock_r && !tx_to_hit
                         && settled;
      rx_enable_o     <= rx_active;
      // (R7) (R11) bus level or latched wake low
      // outside normal and rx-only the output idles recessive until a wake is found
      if (rx_active) begin
        rx_data_out_o <= bus_s;
      end else begin
        rx_data_out_o <= !(mode_r == `TRX_WAKE && (woken_r || wake_found));
      end
      // (R16) (R19) interrupt only in chip stop/normal
      // a sleep or fail-safe wake leaves it idle; software reads the flag instead
      int_n_o <= !(wake_found && (chip_mode_i == `CHIP_STOP || chip_mode_i == `CHIP_NORMAL));
      // (R18) sleep or fail-safe wake asks for restart
      // the sequencer owns the mode change; this is only a one-cycle request
      restart_req_o <= wake_found && (chip_mode_i == `CHIP_SLEEP || chip_mode_i == `CHIP_FAILSAFE);
      // (R17) watchdog switched on by bus wake
      if (wake_found && wdog_cfg_r && chip_mode_i == `CHIP_STOP) begin
        wdog_enable_o <= 1'b1;
      end else if (chip_mode_strobe_i) begin
        wdog_enable_o <= 1'b0;
      end
    end
  end

  // apb slave: one wait state, unmapped addresses answer with an error
  // read data stands only in the answer cycle, so a stale word never lingers on the bus
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else if (ce_i) begin
      pready_o  <= apb_first;
      pslverr_o <= apb_first & ~addr_mapped(paddr_i);
      if (apb_first & ~pwrite_i) begin
        case (paddr_i)
          `REG_CTRL_OFF:      prdata_o <= {29'h0, wdog_cfg_r, mode_r};
          `REG_STATUS_OFF:    prdata_o <= {28'h0, armed_r, clamp_r, txto_r, fail_r};
          `REG_WAKE_STAT_OFF: prdata_o <= {30'h0, wake_wdog_r, wake_flag_r};
          default:            prdata_o <= 32'h00000000;
        endcase
      end else if (apb_rd) begin
        prdata_o <= 32'h00000000;
      end
    end
  end
endmodule

// [verilog/can_trx_map.vh]
`ifndef CAN_TRX_MAP_VH
`define CAN_TRX_MAP_VH

// APB register byte offsets
`define REG_CTRL_OFF      8'h00
`define REG_STATUS_OFF    8'h04
`define REG_WAKE_STAT_OFF 8'h08
// control register fields
`define CTRL_MODE_LSB     0
`define CTRL_MODE_MSB     1
`define CTRL_WDOG_BIT     2
// transceiver mode encodings
`define TRX_OFF           2'h0
`define TRX_WAKE          2'h1
`define TRX_RXONLY        2'h2
`define TRX_NORMAL        2'h3
// chip mode encodings (from the chip mode sequencer)
`define CHIP_NORMAL       3'h0
`define CHIP_STOP         3'h1
`define CHIP_SLEEP        3'h2
`define CHIP_RESTART      3'h3
`define CHIP_FAILSAFE     3'h4
// status bits
`define STAT_FAIL_BIT     0
`define STAT_TXTO_BIT     1
`define STAT_CLAMP_BIT    2
`define STAT_ARMED_BIT    3
`define WAKE_FLAG_BIT     0
`define WAKE_WDOG_BIT     1
// timing defaults in clock cycles (100 ns each)
`define EN_SETTLE_CYC     16'd200
`define WAKE_MIN_CYC      16'd5
`define WAKE_MAX_CYC      16'd18000
`define TX_TO_CYC         16'd45000
`define BUS_TO_CYC        16'd45000

`endif

// [verilog/pin_sync.v]
`timescale 1ns/1ps
// three-stage synchroniser; output moves only when stages two and three agree
module pin_sync (
  // clock and reset
  input  wire clk_i,
  input  wire reset_i,
  input  wire ce_i,
  // pin
  input  wire pin_i,
  output reg  level_o
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // reset value is recessive (high) so no false dominant after reset
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_o <= 1'b1;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule

// [verilog/wake_detect.v]
`timescale 1ns/1ps
// finds dominant-recessive-dominant with the first two phases inside (min, max) and the last one longer than min
module wake_detect (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        ce_i,
  // control
  input  wire        arm_i,
  input  wire        bus_dom_i,
  input  wire [15:0] min_cyc_i,
  input  wire [15:0] max_cyc_i,
  // result
  output reg         found_o
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DOM1 = 2'h1;
  localparam [1:0] ST_REC  = 2'h2;
  localparam [1:0] ST_DOM2 = 2'h3;

  reg [1:0]  state_r;
  reg [15:0] cnt_r;

  // phase length is valid strictly between the two bounds
  function in_window;
    input [15:0] c;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_window = (c > lo) && (c < hi);
    end
  endfunction

  // phase sequencer; a bad phase restarts the search
  // (R10) bounded phase pattern
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 16'h0000;
      found_o <= 1'b0;
    end else if (ce_i) begin
      found_o <= 1'b0;
      if (!arm_i) begin
        state_r <= ST_IDLE;
        cnt_r   <= 16'h0000;
      end else begin
        if (cnt_r != 16'hffff) begin
          cnt_r <= cnt_r + 16'h0001;
        end
        case (state_r)
          ST_IDLE: begin
            cnt_r <= 16'h0001;
            if (bus_dom_i) begin
              state_r <= ST_DOM1;
            end
          end
          ST_DOM1: begin
            if (!bus_dom_i) begin
              cnt_r   <= 16'h0001;
              state_r <= in_window(cnt_r, min_cyc_i, max_cyc_i) ? ST_REC : ST_IDLE;
            end
          end
          ST_REC: begin
            if (bus_dom_i) begin
              cnt_r   <= 16'h0001;
              state_r <= in_window(cnt_r, min_cyc_i, max_cyc_i) ? ST_DOM2 : ST_DOM1;
            end
          end
          ST_DOM2: begin
            // report as soon as the second dominant phase passes the minimum
            if (!bus_dom_i) begin
              cnt_r   <= 16'h0001;
              state_r <= ST_IDLE;
            end else if (cnt_r > min_cyc_i) begin
              found_o <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
